// [rtl/dbc_pkg.sv]
/*
  Shared constants and types for the dual-beam coincidence stop block.
  Assumes a single 10 MHz system clock and an APB master on the register side.
*/
package dbc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 100;
  localparam int NS_PER_MS = 1000000;
  localparam int TICK_MS = 100;
  // Clock cycles per window tick, 1,000,000 at 10 MHz.
  localparam int TICK_CYC = TICK_MS * NS_PER_MS / CLK_NS;
  localparam int WIN_MIN_MS = 200;
  localparam int WIN_MAX_MS = 1000;
  localparam int WIN_DEF_MS = 500;
  localparam logic [3:0] WIN_MIN = 4'(WIN_MIN_MS / TICK_MS);
  localparam logic [3:0] WIN_MAX = 4'(WIN_MAX_MS / TICK_MS);
  localparam logic [3:0] WIN_DEF = 4'(WIN_DEF_MS / TICK_MS);
  localparam int PULSE_MS = 500;
  localparam logic [3:0] PULSE_TK = 4'(PULSE_MS / TICK_MS);
  localparam int FLASH_MS = 500;
  localparam logic [3:0] FLASH_TK = 4'(FLASH_MS / TICK_MS);
  localparam int PWD_MIN = 10;
  localparam int MS_PER_MIN = 60000;
  localparam logic [12:0] PWD_TK = 13'(PWD_MIN * MS_PER_MIN / TICK_MS);

  // ****************************************************************
  // Channels, password and register map
  // ****************************************************************
  localparam int NCH = 8;
  localparam int NPAIR = 4;
  localparam logic [7:0] LIVE_4CH = 8'h0f;
  localparam logic [19:0] PWD_SEQ = 20'h31425;
  localparam logic [2:0] PWD_LAST = 3'h4;
  localparam logic [3:0] RESP_DEF = 4'h4;
  localparam logic [7:0] ADDR_CFG_END = 8'h20;
  localparam logic [7:0] ADDR_KEY = 8'h20;
  localparam logic [7:0] ADDR_STAT = 8'h24;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {MODE_STD, MODE_SYNC, MODE_WEFT, MODE_DUAL} dbc_mode_t;
  typedef enum logic [1:0] {RLY_OFF, RLY_LATCH, RLY_FLASH, RLY_PULSE} dbc_rly_t;
  typedef enum logic [1:0] {PG_START, PG_PWD, PG_UNIT, PG_BASIC} dbc_page_t;
  typedef enum logic [2:0] {CUR_MODE, CUR_RESP, CUR_STOP, CUR_WIN, CUR_RELAY} dbc_cur_t;
  typedef enum logic [2:0] {K_BACK, K_INC, K_DEC, K_UP, K_DOWN, K_FWD, K_UNIT, K_DIGIT}
    dbc_key_t;

  // Per-channel settings; this is also the layout of a CFG register.
  typedef struct packed {
    dbc_rly_t relay;
    logic [3:0] win;
    logic stop_nc;
    logic [3:0] resp;
    dbc_mode_t mode;
  } dbc_cfg_t;

  localparam dbc_cfg_t CFG_RST = '{relay: RLY_OFF, win: WIN_DEF, stop_nc: 1'b0,
                                   resp: RESP_DEF, mode: MODE_STD};

  // Layout of the status register.
  typedef struct packed {
    logic pwd_ok;
    dbc_page_t page;
    dbc_cur_t cur;
    logic [2:0] chan;
    logic stop;
    logic [3:0] stop_num;
  } dbc_stat_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dbc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dbc_apb_rsp_t;

endpackage

// [rtl/dbc_pair.sv]
/*
  Coincidence detector for one monitoring position of two beam channels.
  Assumes one-cycle interruption events and a one-cycle 0.1 s tick enable.
*/
`timescale 1ns/100ps
module dbc_pair
  import dbc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick,
  input wire logic dual_en,
  input wire logic ev_lo,
  input wire logic ev_hi,
  input wire logic [3:0] win,
  output logic stop_evt
);

  typedef struct packed {
    logic arm_lo;
    logic arm_hi;
    logic [3:0] cnt;
    logic stop;
  } dbc_pair_st_t;

  dbc_pair_st_t s_q;
  dbc_pair_st_t s_d;
  logic pend;

  assign pend = s_q.arm_lo | s_q.arm_hi;
  assign stop_evt = s_q.stop;

  // ****************************************************************
  // Window timer
  // ****************************************************************
  // A partner arrival in the tick that would expire the window still counts.
  always_comb
  begin
    s_d = s_q;
    s_d.stop = 1'b0;
    if (!dual_en)
    begin
      s_d = '0;  // [RULE7]
    end
    else if ((s_q.arm_lo && ev_hi) || (s_q.arm_hi && ev_lo) || (ev_lo && ev_hi))
    begin
      s_d = '0;
      s_d.stop = 1'b1;  // [RULE2] [RULE20]
    end
    else if (!pend && (ev_lo || ev_hi))
    begin
      s_d.arm_lo = ev_lo;
      s_d.arm_hi = ev_hi;
      s_d.cnt = win;  // [RULE20] [RULE21]
    end
    else if (pend && tick)
    begin
      if (s_q.cnt <= 4'h1)
      begin
        s_d = '0;  // [RULE3]
      end
      else
      begin
        s_d.cnt = s_q.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_stop_needs_dual: assert property (stop_evt |-> $past(dual_en)) // [RULE3]
    else $error("Pair stop raised outside dual-beam mode.");
  a_expiry_clears: assert property ( // [RULE20]
    (pend && tick && s_q.cnt == 4'h1 && !ev_lo && !ev_hi && dual_en) |=> !pend && !stop_evt)
    else $error("Expired window did not clear the pending event.");
  a_arm_loads_win: assert property ( // [RULE21]
    (!pend && dual_en && (ev_lo ^ ev_hi)) |=> pend && s_q.cnt == $past(win))
    else $error("Window timer not loaded on first interruption.");

endmodule

// [rtl/dbc_top.sv]
/*
  Dual-beam coincidence stop: eight beam channels, machine stop, relay board
  outputs and the operator menu, driven by key codes written over APB.
  Assumes synchronous inputs, one 10 MHz clock and a synchronous reset.
*/
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps

// Behaviour
// RULE1: Channels pair 1-2, 3-4, 5-6, 7-8.
// RULE2: Dual pair stops when both interrupt in window.
// RULE3: One beam or late second beam: no stop.
// RULE4: Window 0.2 to 1.0 s, default 0.5 s.
// RULE5: Window setting shown only in dual-beam mode.
// RULE6: Dual stop reports pair's lower channel number.
// RULE7: Both pair channels set dual by configurer.
// RULE8: Configurer sets pair settings identically.
// RULE9: Settings page needs password within ten minutes.
// RULE10: Password is digits 3,1,4,2,5.
// RULE11: Inc/dec edit, up/down move, skip channel.
// RULE12: Relay mode shown only with relay board.
// RULE13: Relay mode 0 keeps relay off.
// RULE14: Relay mode 1 latches until restart.
// RULE15: Relay mode 2 flashes until restart.
// RULE16: Pulse mode drives relay only, no stop.
// RULE17: Pulse relay on about 0.5 s.
// RULE18: Pulse mode allowed only in standard mode.
// RULE19: One relay per channel, second group optional.
// RULE20: First interruption starts timer, expiry clears.
// RULE21: Window kept and timed in 0.1 s steps.
module dbc_top
  import dbc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic board_8ch,
  input wire logic relay_board,
  input wire logic restart,
  input wire logic [7:0] beam_int,
  input wire dbc_pkg::dbc_apb_req_t apb_req,
  output dbc_pkg::dbc_apb_rsp_t apb_rsp,
  output logic stop_q,
  output logic [3:0] stop_chan,
  output logic [7:0] relay_q
);
  import dbc_pkg::*;

  typedef struct packed {
    logic [19:0] div;
    logic [3:0] fl_cnt;
    logic fl_ph;
    logic [7:0] beam_prev;
    dbc_cfg_t [NCH-1:0] cfg;
    logic [7:0] latch;
    logic [NCH-1:0][3:0] pcnt;
    logic [7:0] relay;
    logic stop;
    logic [2:0] stop_idx;
    dbc_page_t page;
    dbc_cur_t cur;
    logic [2:0] chan;
    logic [2:0] pidx;
    logic [12:0] pwd_tk;
    logic [31:0] prdata;
    logic pslverr;
  } dbc_state_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // A field is on screen only if its mode or the relay board allows it.
  function automatic logic cur_ok(dbc_cur_t c, dbc_mode_t m, logic b);
    cur_ok = 1'b1;
    if (c == CUR_WIN)
      cur_ok = (m == MODE_DUAL);  // [RULE5]
    else if (c == CUR_RELAY)
      cur_ok = b;  // [RULE12]
  endfunction

  // Moves to the nearest visible field; the channel field is not a stop.
  function automatic dbc_cur_t cur_step(dbc_cur_t c, logic dn, dbc_mode_t m, logic b);
    int v;
    dbc_cur_t r;
    r = c;
    v = int'(c);
    for (int k = 0; k < 4; k++)
    begin
      v = dn ? v + 1 : v - 1;
      if (v >= 0 && v <= 4 && r == c && cur_ok(dbc_cur_t'(3'(v)), m, b))
        r = dbc_cur_t'(3'(v));  // [RULE11]
    end
    return r;
  endfunction

  dbc_state_t s_q;
  dbc_state_t s_d;
  logic [NPAIR-1:0] pair_stop;
  logic [7:0] ev;
  logic [7:0] live;
  logic tick;

  assign live = board_8ch ? 8'hff : LIVE_4CH;  // [RULE1] [RULE19]
  assign ev = beam_int & ~s_q.beam_prev & live;

  // ****************************************************************
  // Coincidence detectors, one per monitoring position
  // ****************************************************************
  // The window comes from the lower channel only, so both must match.
  for (genvar p = 0; p < NPAIR; p++)
  begin : g_pair
    dbc_pair u_pair (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick(tick),
      .dual_en(s_q.cfg[2*p].mode == MODE_DUAL && s_q.cfg[2*p+1].mode == MODE_DUAL),
      .ev_lo(ev[2*p]),
      .ev_hi(ev[2*p+1]),
      .win(s_q.cfg[2*p].win),  // [RULE8]
      .stop_evt(pair_stop[p])
    );
  end

  logic [7:0] fault;
  logic setup;
  logic access;
  logic kv;
  dbc_key_t kc;
  logic [3:0] kd;
  dbc_cfg_t c;
  dbc_rly_t r;
  dbc_stat_t st;
  logic [7:0] a;

  assign tick = (s_q.div == 20'(TICK_CYCLES - 1));
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign a = apb_req.paddr;
  // A key press is a write to the key register, taken at the access edge.
  assign kv = access & apb_req.pwrite & (a == ADDR_KEY);
  assign kc = dbc_key_t'(apb_req.pwdata[2:0]);
  assign kd = apb_req.pwdata[7:4];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    fault = '0;
    c = s_q.cfg[s_q.chan];
    r = c.relay;
    st = '0;
    s_d.div = tick ? 20'h0 : s_q.div + 20'h1;
    s_d.beam_prev = beam_int;
    if (tick)
    begin
      s_d.fl_cnt = (s_q.fl_cnt == FLASH_TK - 4'h1) ? 4'h0 : s_q.fl_cnt + 4'h1;
      if (s_q.fl_cnt == FLASH_TK - 4'h1)
        s_d.fl_ph = ~s_q.fl_ph;
      if (s_q.pwd_tk != 13'h0)
        s_d.pwd_tk = s_q.pwd_tk - 13'h1;  // [RULE9]
    end
    // A dual channel faults only on its pair's coincidence; others on an edge.
    for (int i = 0; i < NCH; i++)
      fault[i] = (s_q.cfg[i].mode == MODE_DUAL) ? pair_stop[i/2] : ev[i];
    // Restart clears first so that a fault in the same cycle still lands.
    if (restart)
    begin
      s_d.stop = 1'b0;
      s_d.latch = '0;
    end
    // Lowest channel wins when several fault at once.
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (fault[i] && s_q.cfg[i].relay != RLY_PULSE && (!s_q.stop || restart))  // [RULE16]
      begin
        s_d.stop = 1'b1;  // [RULE2]
        s_d.stop_idx = (s_q.cfg[i].mode == MODE_DUAL) ? 3'(i & 6) : 3'(i);  // [RULE6]
      end
    end
    // Relay outputs; delay here is harmless since they never stop the machine.
    for (int i = 0; i < NCH; i++)
    begin
      unique case (s_q.cfg[i].relay)
        RLY_OFF:
        begin
          s_d.latch[i] = 1'b0;
          s_d.pcnt[i] = 4'h0;
          s_d.relay[i] = 1'b0;  // [RULE13]
        end
        RLY_LATCH:
        begin
          if (fault[i])
            s_d.latch[i] = 1'b1;
          s_d.relay[i] = s_d.latch[i];  // [RULE14]
        end
        RLY_FLASH:
        begin
          if (fault[i])
            s_d.latch[i] = 1'b1;
          s_d.relay[i] = s_d.latch[i] & s_q.fl_ph;  // [RULE15]
        end
        RLY_PULSE:
        begin
          if (fault[i])
            s_d.pcnt[i] = PULSE_TK;  // [RULE17]
          else if (tick && s_q.pcnt[i] != 4'h0)
            s_d.pcnt[i] = s_q.pcnt[i] - 4'h1;
          s_d.relay[i] = (s_d.pcnt[i] != 4'h0);  // [RULE16]
        end
      endcase
    end
    s_d.relay = s_d.relay & live;  // [RULE19]
    // Menu walk driven by key codes.
    if (kv)
    begin
      unique case (s_q.page)
        PG_START:
        begin
          if (kc == K_FWD && s_q.pwd_tk != 13'h0 && (kd < 4'h4 || (board_8ch && kd < 4'h8)))
          begin
            s_d.page = PG_BASIC;  // [RULE9]
            s_d.chan = kd[2:0];
            s_d.cur = CUR_MODE;
          end
          else if (kc == K_UNIT)
          begin
            s_d.page = PG_PWD;
            s_d.pidx = 3'h0;
          end
        end
        PG_PWD:
        begin
          if (kc == K_DIGIT && kd == PWD_SEQ[19 - 4*s_q.pidx -: 4])  // [RULE10]
          begin
            s_d.pidx = s_q.pidx + 3'h1;
            if (s_q.pidx == PWD_LAST)
            begin
              s_d.page = PG_UNIT;
              s_d.pwd_tk = PWD_TK;
            end
          end
          else
          begin
            s_d.page = PG_START;
          end
        end
        PG_UNIT:
        begin
          if (kc == K_BACK)
            s_d.page = PG_START;
        end
        PG_BASIC:
        begin
          unique case (kc)
            K_UP: s_d.cur = cur_step(s_q.cur, 1'b0, c.mode, relay_board);  // [RULE11]
            K_DOWN: s_d.cur = cur_step(s_q.cur, 1'b1, c.mode, relay_board);
            K_INC, K_DEC:
            begin
              unique case (s_q.cur)
                CUR_MODE:
                begin
                  c.mode = dbc_mode_t'(kc == K_INC ? c.mode + 2'h1 : c.mode - 2'h1);
                  if (c.mode != MODE_STD && c.relay == RLY_PULSE)
                    c.relay = RLY_OFF;  // [RULE18]
                end
                CUR_RESP:
                begin
                  if (kc == K_INC && c.resp != 4'hf)
                    c.resp = c.resp + 4'h1;
                  else if (kc == K_DEC && c.resp != 4'h0)
                    c.resp = c.resp - 4'h1;
                end
                CUR_STOP: c.stop_nc = ~c.stop_nc;  // [RULE11]
                CUR_WIN:
                begin
                  if (kc == K_INC && c.win < WIN_MAX)
                    c.win = c.win + 4'h1;  // [RULE4] [RULE21]
                  else if (kc == K_DEC && c.win > WIN_MIN)
                    c.win = c.win - 4'h1;
                end
                CUR_RELAY:
                begin
                  r = dbc_rly_t'(kc == K_INC ? c.relay + 2'h1 : c.relay - 2'h1);
                  if (r != RLY_PULSE || c.mode == MODE_STD)
                    c.relay = r;  // [RULE18]
                end
                default: c = s_q.cfg[s_q.chan];
              endcase
              s_d.cfg[s_q.chan] = c;
            end
            default: s_d.page = PG_START;
          endcase
        end
      endcase
    end
    // Read data is staged in the setup cycle so that it leaves a flip-flop.
    st = '{pwd_ok: s_q.pwd_tk != 13'h0, page: s_q.page, cur: s_q.cur, chan: s_q.chan,
           stop: s_q.stop, stop_num: s_q.stop ? {1'b0, s_q.stop_idx} + 4'h1 : 4'h0};
    if (setup)
    begin
      s_d.prdata = 32'h0;
      s_d.pslverr = 1'b0;
      if (a[1:0] != 2'h0 || a > ADDR_STAT)
        s_d.pslverr = 1'b1;
      else if (a < ADDR_CFG_END)
      begin
        s_d.pslverr = apb_req.pwrite;
        s_d.prdata = 32'(s_q.cfg[a[4:2]]);
      end
      else if (a == ADDR_STAT)
      begin
        s_d.pslverr = apb_req.pwrite;
        s_d.prdata = 32'(st);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.cfg <= {NCH{CFG_RST}};  // [RULE4]
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access & s_q.pslverr;
  assign apb_rsp.prdata = s_q.prdata;
  assign stop_q = s_q.stop;
  assign stop_chan = s_q.stop ? {1'b0, s_q.stop_idx} + 4'h1 : 4'h0;
  assign relay_q = s_q.relay;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [7:0] off_m;
  logic win_ok;
  logic pulse_ok;

  always_comb
  begin
    off_m = '0;
    win_ok = 1'b1;
    pulse_ok = 1'b1;
    for (int i = 0; i < NCH; i++)
    begin
      off_m[i] = (s_q.cfg[i].relay == RLY_OFF);
      win_ok = win_ok & s_q.cfg[i].win >= WIN_MIN & s_q.cfg[i].win <= WIN_MAX;
      pulse_ok = pulse_ok & (s_q.cfg[i].relay != RLY_PULSE || s_q.cfg[i].mode == MODE_STD);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_stop_holds: assert property (stop_q && !restart |=> stop_q) // [RULE2]
    else $error("Machine stop dropped without restart.");
  a_stop_chan_low: assert property ( // [RULE6]
    $rose(stop_q) && s_q.cfg[s_q.stop_idx].mode == MODE_DUAL |-> stop_chan[0])
    else $error("Dual stop reported the upper channel.");
  a_relay_mode0: assert property ((relay_q & $past(off_m)) == 8'h0) // [RULE13]
    else $error("Relay on in relay mode 0.");
  a_basic_gate: assert property ( // [RULE9]
    s_q.page == PG_BASIC && $past(s_q.page) != PG_BASIC |-> $past(s_q.pwd_tk) != 13'h0)
    else $error("Settings page entered without a live password.");
  a_win_range: assert property (win_ok) // [RULE4]
    else $error("Window outside 0.2 to 1.0 s.");
  a_cursor_shown: assert property ( // [RULE5]
    s_q.page == PG_BASIC |-> cur_ok(s_q.cur, s_q.cfg[s_q.chan].mode, relay_board))
    else $error("Cursor on a hidden field.");
  a_pulse_std: assert property (pulse_ok) // [RULE18]
    else $error("Pulse relay mode on a non-standard channel.");
  a_grp2_off: assert property (!board_8ch |=> relay_q[7:4] == 4'h0) // [RULE19]
    else $error("Second relay group active in four-channel build.");

endmodule

// [tb/dbc_beam_model.sv]
/*
  Behavioural model of the eight beam receivers in front of the block.
  Assumes the bench raises one bit of fire for one cycle per interruption.
*/
`timescale 1ns/100ps
module dbc_beam_model
#(
  parameter int HOLD = 3
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] fire,
  output logic [7:0] beam_int
);
  int cnt_q [8];

  // Each beam stays dark for HOLD cycles, then clears so the next thread
  // gives a fresh rising edge.
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (rst)
        cnt_q[i] <= 0;
      else if (fire[i])
        cnt_q[i] <= HOLD;
      else if (cnt_q[i] > 0)
        cnt_q[i] <= cnt_q[i] - 1;
    end
  end

  // The receiver output is a plain level while the beam is blocked.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      beam_int[i] = (cnt_q[i] > 0);
  end
endmodule

// [tb/dbc_top_test.sv]
/*
  Self-checking bench for the coincidence stop block: APB menu keys, beams, relays.
  Assumes the design answers APB with no wait states and a 10-cycle tick.
*/
`timescale 1ns/100ps
module dbc_top_test;
  import dbc_pkg::*;
  logic clk_sys;
  logic rst;
  logic restart;
  logic board_8ch;
  logic [7:0] fire;
  logic [7:0] beam_int;
  dbc_apb_req_t apb_req;
  dbc_apb_rsp_t apb_rsp;
  logic stop_q;
  logic [3:0] stop_chan;
  logic [7:0] relay_q;
  int error_cnt;
  int total_checks;
  int n;
  logic [31:0] r;
  logic e;
  logic last;
  dbc_stat_t st;
  logic [3:0] pwd [5] = '{4'h3, 4'h1, 4'h4, 4'h2, 4'h5};

  // ****************************************************************
  // Design, beams and clock
  // ****************************************************************
  dbc_top #(.TICK_CYCLES(10)) u_dbc_top (.clk_sys(clk_sys), .rst(rst), .board_8ch(board_8ch),
    .relay_board(1'b1), .restart(restart), .beam_int(beam_int), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .stop_q(stop_q), .stop_chan(stop_chan), .relay_q(relay_q));
  dbc_beam_model u_dbc_beam_model (.clk_sys(clk_sys), .rst(rst), .fire(fire),
    .beam_int(beam_int));

  // Free-running 10 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd_d, output logic err);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (apb_rsp.pready !== 1'b1);
    rd_d = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic x;
    apb(1'b0, a, 32'h0, d, x);
  endtask

  task automatic key(input dbc_key_t k, input logic [3:0] v);
    logic [31:0] d;
    logic x;
    apb(1'b1, ADDR_KEY, {24'h0, v, 1'b0, k}, d, x);
  endtask

  task automatic keys(input dbc_key_t k, input int cnt);
    for (int i = 0; i < cnt; i++)
      key(k, 4'h0);
  endtask

  task automatic stat(output dbc_stat_t s);
    logic [31:0] d;
    rd(ADDR_STAT, d);
    s = d[13:0];
  endtask

  // Waits whole cycles and then half a cycle, so outputs have settled.
  task automatic settle(input int cnt);
    repeat (cnt) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic fire_ch(input logic [7:0] m);
    @(posedge clk_sys);
    fire <= m;
    @(posedge clk_sys);
    fire <= 8'h00;
  endtask

  task automatic restart_pulse();
    @(posedge clk_sys);
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
    settle(2);
  endtask

  function automatic logic [31:0] mk(dbc_rly_t rl, logic [3:0] w, dbc_mode_t m);
    dbc_cfg_t c;
    c = '{relay: rl, win: w, stop_nc: 1'b0, resp: RESP_DEF, mode: m};
    return 32'(c);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  // Main sequence of menu, beam and relay scenarios.
  initial
  begin
    rst = 1'b1;
    restart = 1'b0;
    board_8ch = 1'b1;
    fire = 8'h00;
    apb_req = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(4 * i), r);
      chk(r, mk(RLY_OFF, 4'h5, MODE_STD));
    end
    apb(1'b0, 8'h28, 32'h0, r, e);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h00, 32'h1fff, r, e);
    chk(32'(e), 32'h1);
    key(K_FWD, 4'h0);
    stat(st);
    chk(32'(st.page), 32'(PG_START));
    key(K_UNIT, 4'h0);
    foreach (pwd[i])
      key(K_DIGIT, pwd[i]);
    stat(st);
    chk(32'({st.pwd_ok, st.page}), 32'({1'b1, PG_UNIT}));
    key(K_BACK, 4'h0);
    // Both beams of position A get dual mode and a 0.2 s window.
    for (int c = 0; c < 2; c++)
    begin
      key(K_FWD, 4'(c));
      keys(K_INC, 3);
      keys(K_DOWN, 3);
      stat(st);
      chk(32'(st.cur), 32'(CUR_WIN));
      keys(K_DEC, 4);
      key(K_BACK, 4'h0);
      rd(8'(4 * c), r);
      chk(r, mk(RLY_OFF, 4'h2, MODE_DUAL));
    end
    fire_ch(8'h01);
    fire_ch(8'h02);
    n = 0;
    while (stop_q !== 1'b1 && n < 10)
    begin
      settle(0);
      n++;
    end
    chk(32'({stop_q, stop_chan}), 32'h11);
    restart_pulse();
    fire_ch(8'h01);
    settle(50);
    chk(32'(stop_q), 32'h0);
    fire_ch(8'h01);
    settle(40);
    fire_ch(8'h02);
    settle(30);
    chk(32'(stop_q), 32'h0);
    key(K_FWD, 4'h2);
    keys(K_DOWN, 3);
    stat(st);
    chk(32'(st.cur), 32'(CUR_RELAY));
    key(K_INC, 4'h0);
    fire_ch(8'h04);
    settle(25);
    chk(32'({stop_q, stop_chan, relay_q}), 32'h1_3_04);
    restart_pulse();
    chk(32'({stop_q, relay_q}), 32'h0);
    key(K_INC, 4'h0);
    fire_ch(8'h04);
    n = 0;
    last = relay_q[2];
    for (int i = 0; i < 150; i++)
    begin
      settle(0);
      n += (relay_q[2] !== last);
      last = relay_q[2];
    end
    chk(32'(n >= 2), 32'h1);
    restart_pulse();
    chk(32'(relay_q), 32'h0);
    key(K_INC, 4'h0);
    rd(8'h08, r);
    chk(r, mk(RLY_PULSE, 4'h5, MODE_STD));
    fire_ch(8'h04);
    settle(30);
    chk(32'({stop_q, relay_q}), 32'h004);
    settle(30);
    chk(32'({stop_q, relay_q}), 32'h000);
    key(K_INC, 4'h0);
    fire_ch(8'h04);
    settle(3);
    chk(32'({stop_q, relay_q}), 32'h100);
    restart_pulse();
    // In the four-channel build a thread on channel 5 must be ignored.
    @(posedge clk_sys);
    board_8ch <= 1'b0;
    fire_ch(8'h10);
    settle(5);
    chk(32'({stop_q, relay_q}), 32'h0);
    @(posedge clk_sys);
    board_8ch <= 1'b1;
    key(K_BACK, 4'h0);
    key(K_FWD, 4'h0);
    keys(K_DOWN, 4);
    keys(K_INC, 3);
    key(K_BACK, 4'h0);
    rd(8'h00, r);
    chk(r, mk(RLY_FLASH, 4'h2, MODE_DUAL));
    settle(60100);
    key(K_FWD, 4'h0);
    stat(st);
    chk(32'(st.page), 32'(PG_START));
    report_and_stop();
  end

  // Cuts a hang short well beyond the expected run of about 61,000 cycles.
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
endmodule
